// File: buck_consts.svh
// buck_consts.svh: register offsets, field widths, reset values, ramp timing counts
// assumes: included by bare name; pclk period is PCLK_NS
`ifndef BUCK_CONSTS_SVH
`define BUCK_CONSTS_SVH

`define ADDR_CTRL      8'h00
`define ADDR_BANK_A    8'h04
`define ADDR_BANK_B    8'h08
`define ADDR_CEILING   8'h0C
`define ADDR_TRIM      8'h10
`define ADDR_STATUS    8'h14

// control word layout, matches ctrl_reg_t
`define CTRL_W         9
`define BANK_W         10
`define CODE_W         8
`define TRIM_W         5

`define RST_CTRL       9'h000
`define RST_BANK       10'h000
// 0.3 V + 160 x 10 mV = 1.9 V
`define RST_CEILING    8'hA0
`define RST_TRIM       5'h00

// code 0 is 0.3 V, one code is 10 mV
`define BASE_MV        300
`define STEP_MV        10

`define PCLK_NS        8
`define STEP_NS_8US    8000
`define STEP_NS_4US    4000
`define STEP_NS_2US    2000
`define STEP_NS_1US    1000
`define STEP_NS_HALF   500
`define CYC(ns)        (((ns) + `PCLK_NS - 1) / `PCLK_NS)
`define STEP_CYC_8US   `CYC(`STEP_NS_8US)
`define STEP_CYC_4US   `CYC(`STEP_NS_4US)
`define STEP_CYC_2US   `CYC(`STEP_NS_2US)
`define STEP_CYC_1US   `CYC(`STEP_NS_1US)
`define STEP_CYC_HALF  `CYC(`STEP_NS_HALF)

`endif

// File: buck_pkg.sv
// buck_pkg.sv: types shared by the voltage control logic
// assumes: field order of ctrl_reg_t matches the control word bit positions
`default_nettype none

package buck_pkg;

   typedef enum logic [1:0] {
      MODE_AUTO,
      MODE_PFM,
      MODE_PWM,
      MODE_AUTO_ALT
   } bank_mode_t;

   typedef struct packed {
      bank_mode_t  mode;
      logic [7:0]  code;
   } bank_reg_t;

   typedef struct packed {
      logic        pg_pin;
      logic [1:0]  pd_dis;
      logic [2:0]  rate;
      logic        pin_sel;
      logic        bank;
      logic        enable;
   } ctrl_reg_t;

   typedef struct packed {
      logic        load_light;
      logic        load_high;
      logic        over_hv;
      logic        below_fall;
      logic        above_rise;
      logic        sel_pin;
   } sense_t;

   typedef enum logic {
      RAMP_IDLE,
      RAMP_RUN
   } ramp_state_t;

endpackage : buck_pkg

`default_nettype wire

// File: step_ticker.sv
// step_ticker.sv: pulses tick once every interval cycles while run is high
// assumes: interval is at least 2 and stable while run is high
`default_nettype none

module step_ticker #(
   parameter int CW = 10
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          run,
   input  wire logic [CW-1:0] interval,
   output logic               tick
);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_tick;

   always_comb begin
      next_count = count;
      next_tick  = 1'b0;
      if (!run) begin
         next_count = '0;
      end else if (count >= interval - CW'(1)) begin
         next_count = '0;
         next_tick  = 1'b1;
      end else begin
         next_count = count + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end

endmodule : step_ticker

`default_nettype wire

// File: buck_voltage_control.sv
// buck_voltage_control.sv: voltage bank, ramp, mode and power-good control of one channel
// assumes: APB master on pclk; comparator and pin inputs are asynchronous to pclk
//
// The APB register port and the register offsets were chosen for this implementation.
`default_nettype none
`include "buck_consts.svh"

module buck_voltage_control
   import buck_pkg::*;
#(
   parameter int CW = 10
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        select_input_pin,
   input  wire logic        above_good_rising_threshold,
   input  wire logic        below_good_falling_threshold,
   input  wire logic        above_overvoltage_threshold,
   input  wire logic        load_above_changeover,
   input  wire logic        load_light,
   output logic      [7:0]  vout_code,
   output logic             conv_pfm,
   output logic             dual_phase,
   output logic      [1:0]  pulldown_en,
   output logic      [4:0]  oscillator_trim,
   output logic             output_good_flag,
   output logic             pg_pin_out,
   output logic             pg_pin_oe_n
);

   // input synchronisers
   sense_t sense_meta;
   sense_t sense_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_meta <= '0;
         sense_sync <= '0;
      end else begin
         sense_meta <= sense_t'({load_light, load_above_changeover,
                                 above_overvoltage_threshold, below_good_falling_threshold,
                                 above_good_rising_threshold, select_input_pin});
         sense_sync <= sense_meta;
      end
   end

   // register file and bus
   ctrl_reg_t   ctrl;
   bank_reg_t   bank_a;
   bank_reg_t   bank_b;
   logic [7:0]  voltage_ceiling;
   ctrl_reg_t   next_ctrl;
   bank_reg_t   next_bank_a;
   bank_reg_t   next_bank_b;
   logic [7:0]  next_voltage_ceiling;
   logic [4:0]  next_oscillator_trim;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        mapped;
   logic        ramping;
   logic        voltage_bank_select;
   logic [31:0] read_word;

   always_comb begin
      case (paddr)
         `ADDR_CTRL:    read_word = {23'h000000, ctrl};
         `ADDR_BANK_A:  read_word = {22'h000000, bank_a};
         `ADDR_BANK_B:  read_word = {22'h000000, bank_b};
         `ADDR_CEILING: read_word = {24'h000000, voltage_ceiling};
         `ADDR_TRIM:    read_word = {27'h0000000, oscillator_trim};
         `ADDR_STATUS:  read_word = {16'h0000, vout_code, 5'h00, voltage_bank_select,
                                    ramping, output_good_flag};
         default:       read_word = 32'h00000000;
      endcase
      mapped = (paddr == `ADDR_CTRL) || (paddr == `ADDR_BANK_A) ||
               (paddr == `ADDR_BANK_B) || (paddr == `ADDR_CEILING) ||
               (paddr == `ADDR_TRIM) || (paddr == `ADDR_STATUS);
   end

   always_comb begin
      next_ctrl            = ctrl;
      next_bank_a          = bank_a;
      next_bank_b          = bank_b;
      next_voltage_ceiling = voltage_ceiling;
      next_oscillator_trim = oscillator_trim;
      next_prdata          = prdata;
      next_pready          = psel & penable & ~pready;
      next_pslverr         = 1'b0;
      // one wait state: answer prepared in the first access cycle
      if (psel && penable && !pready) begin
         next_pslverr = ~mapped;
         next_prdata  = (mapped && !pwrite) ? read_word : 32'h00000000;
      end
      if (psel && penable && pready && pwrite && !pslverr) begin
         case (paddr)
            `ADDR_CTRL:    next_ctrl            = ctrl_reg_t'(pwdata[`CTRL_W-1:0]);
            `ADDR_BANK_A:  next_bank_a          = bank_reg_t'(pwdata[`BANK_W-1:0]);
            `ADDR_BANK_B:  next_bank_b          = bank_reg_t'(pwdata[`BANK_W-1:0]);
            `ADDR_CEILING: next_voltage_ceiling = pwdata[`CODE_W-1:0];
            `ADDR_TRIM:    next_oscillator_trim = pwdata[`TRIM_W-1:0];
            default:       next_ctrl            = ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl            <= ctrl_reg_t'(`RST_CTRL);
         bank_a          <= bank_reg_t'(`RST_BANK);
         bank_b          <= bank_reg_t'(`RST_BANK);
         voltage_ceiling <= `RST_CEILING;
         oscillator_trim <= `RST_TRIM;
         prdata          <= 32'h00000000;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
      end else begin
         ctrl            <= next_ctrl;
         bank_a          <= next_bank_a;
         bank_b          <= next_bank_b;
         voltage_ceiling <= next_voltage_ceiling;
         oscillator_trim <= next_oscillator_trim;
         prdata          <= next_prdata;
         pready          <= next_pready;
         pslverr         <= next_pslverr;
      end
   end

   // target selection and clamp
   bank_reg_t  active;
   logic [7:0] clamped_target;
   logic [CW-1:0] step_interval;
   logic          step_tick;

   always_comb begin
      // bank A after reset unless the pin selects
      voltage_bank_select = ctrl.pin_sel ? sense_sync.sel_pin : ctrl.bank;
      active              = voltage_bank_select ? bank_b : bank_a;
      clamped_target      = (active.code > voltage_ceiling) ? voltage_ceiling
                                                            : active.code;
      case (ctrl.rate)
         3'h0:    step_interval = CW'(`STEP_CYC_8US);
         3'h1:    step_interval = CW'(`STEP_CYC_4US);
         3'h2:    step_interval = CW'(`STEP_CYC_2US);
         3'h3:    step_interval = CW'(`STEP_CYC_1US);
         default: step_interval = CW'(`STEP_CYC_HALF);
      endcase
   end

   // ramp controller
   ramp_state_t ramp_state;
   ramp_state_t next_ramp_state;
   logic [7:0]  next_vout_code;

   assign ramping = (ramp_state == RAMP_RUN);

   step_ticker #(
      .CW (CW)
   ) u_step_ticker (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (ramping),
      .interval (step_interval),
      .tick     (step_tick)
   );

   always_comb begin
      next_ramp_state = ramp_state;
      next_vout_code  = vout_code;
      if (!ctrl.enable) begin
         // disabled: no ramp, target tracked directly
         next_ramp_state = RAMP_IDLE;
         next_vout_code  = clamped_target;
      end else begin
         case (ramp_state)
            RAMP_IDLE: begin
               if (clamped_target != vout_code) begin
                  next_ramp_state = RAMP_RUN;
               end
            end
            RAMP_RUN: begin
               if (clamped_target == vout_code) begin
                  next_ramp_state = RAMP_IDLE;
               end else if (step_tick) begin
                  // one code is 10 mV above 0.3 V
                  next_vout_code = (clamped_target > vout_code) ? vout_code + 8'h01
                                                                : vout_code - 8'h01;
               end
            end
            default: next_ramp_state = RAMP_IDLE;
         endcase
      end
   end

   // mode, phase, pull-down and power-good
   logic       next_conv_pfm;
   logic       next_dual_phase;
   logic [1:0] next_pulldown_en;
   logic       next_good;
   logic       next_pg_pin_out;
   logic       next_pg_pin_oe_n;

   always_comb begin
      next_conv_pfm = 1'b0;
      if (ctrl.enable && next_ramp_state == RAMP_IDLE) begin
         case (active.mode)
            MODE_PFM:      next_conv_pfm = 1'b1;
            MODE_PWM:      next_conv_pfm = 1'b0;
            default:       next_conv_pfm = sense_sync.load_light;
         endcase
      end
      next_dual_phase  = ctrl.enable & sense_sync.load_high;
      next_pulldown_en = ~ctrl.pd_dis;
      next_good        = output_good_flag;
      if (!ctrl.enable) begin
         next_good = 1'b0;
      end else if (sense_sync.below_fall || sense_sync.over_hv) begin
         next_good = 1'b0;
      end else if (sense_sync.above_rise) begin
         next_good = 1'b1;
      end
      next_pg_pin_out  = ctrl.pg_pin & output_good_flag;
      next_pg_pin_oe_n = ~ctrl.pg_pin;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_state       <= RAMP_IDLE;
         vout_code        <= 8'h00;
         conv_pfm         <= 1'b0;
         dual_phase       <= 1'b0;
         pulldown_en      <= 2'h3;
         output_good_flag <= 1'b0;
         pg_pin_out       <= 1'b0;
         pg_pin_oe_n      <= 1'b1;
      end else begin
         ramp_state       <= next_ramp_state;
         vout_code        <= next_vout_code;
         conv_pfm         <= next_conv_pfm;
         dual_phase       <= next_dual_phase;
         pulldown_en      <= next_pulldown_en;
         output_good_flag <= next_good;
         pg_pin_out       <= next_pg_pin_out;
         pg_pin_oe_n      <= next_pg_pin_oe_n;
      end
   end

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   good_off_clear_a: assert property (!ctrl.enable |=> !output_good_flag)
      else $error("good flag set while disabled");
   good_rise_set_a: assert property (ctrl.enable && sense_sync.above_rise &&
      !sense_sync.below_fall && !sense_sync.over_hv |=> output_good_flag)
      else $error("good flag not set above rising threshold");
   good_drop_a: assert property ((sense_sync.below_fall || sense_sync.over_hv)
      |=> !output_good_flag)
      else $error("good flag kept below falling or above overvoltage threshold");
   status_good_a: assert property (psel && penable && !pready && !pwrite &&
      paddr == `ADDR_STATUS |=> pready && prdata[0] == $past(output_good_flag))
      else $error("status read does not show good flag");
   good_pin_a: assert property (ctrl.pg_pin |=>
      !pg_pin_oe_n && pg_pin_out == $past(output_good_flag))
      else $error("pin does not follow good flag");
   ramp_pwm_a: assert property (ramping |-> !conv_pfm)
      else $error("PFM selected during ramp");
   ramp_step_a: assert property (ctrl.enable && $past(ctrl.enable) |->
      vout_code == $past(vout_code) || vout_code == $past(vout_code) + 8'h01 ||
      vout_code == $past(vout_code) - 8'h01)
      else $error("ramp moved more than one step");
   step_rate_a: assert property (ramping && ctrl.rate == 3'h4 && step_tick |->
      ##1 !step_tick [*8])
      else $error("steps closer than the programmed interval");
   settled_ceiling_a: assert property (ramp_state == RAMP_IDLE && ctrl.enable &&
      $past(ramp_state == RAMP_IDLE && ctrl.enable) && $stable(clamped_target)
      |-> vout_code == clamped_target && vout_code <= voltage_ceiling)
      else $error("settled output not at clamped target");
   pulldown_a: assert property (1'b1 |=> pulldown_en == ~$past(ctrl.pd_dis))
      else $error("pull-down does not follow disable bits");
   bank_start_a: assert property (ctrl.enable && $changed(voltage_bank_select) &&
      $stable(ctrl.enable) && bank_a.code != bank_b.code &&
      vout_code != clamped_target |=> ramping)
      else $error("bank switch did not start a ramp");

   ramp_seen_c: cover property (ramp_state == RAMP_IDLE ##1 ramping);
   good_rise_c: cover property ($rose(output_good_flag));
   bank_switch_c: cover property (ctrl.enable && $changed(voltage_bank_select));
   ramp_done_c: cover property (ramping ##1 ramp_state == RAMP_IDLE);

endmodule : buck_voltage_control

`default_nettype wire

// File: rail_model.sv
// rail_model.sv: behavioural output rail and load seen by the voltage control block
// assumes: driven on pclk; the rail counts as settled once the code has held for 4 cycles
`default_nettype none

module rail_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] vout_code,
   input  wire logic       droop,
   input  wire logic       surge,
   input  wire logic [1:0] load_level,
   output logic            above_rise,
   output logic            below_fall,
   output logic            above_hv,
   output logic            load_high,
   output logic            load_light
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_code;
   logic [2:0] settle_cnt;

   // a moving target keeps the rail below the rising threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_code  <= 8'h00;
         settle_cnt <= 3'h0;
      end else begin
         last_code  <= vout_code;
         settle_cnt <= (vout_code != last_code) ? 3'h0 :
                       (settle_cnt == 3'h7) ? 3'h7 : settle_cnt + 3'h1;
      end
   end

   assign above_rise = (settle_cnt >= 3'h4) && !droop;
   assign below_fall = droop;
   assign above_hv   = surge;
   assign load_high  = (load_level == 2'h2);
   assign load_light = (load_level == 2'h0);
endmodule : rail_model

`default_nettype wire

// File: buck_voltage_control_logic_bench.sv
// buck_voltage_control_logic_bench.sv: self-checking bench for the voltage control block
// assumes: package, design and rail_model compiled first; APB slave answers within 20 cycles
`default_nettype none
`include "buck_consts.svh"

module buck_voltage_control_logic_bench
   import buck_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e, sel_pin = 1'b0, droop = 1'b0, surge = 1'b0;
   logic [1:0]  load_level = 2'h1, pulldown_en;
   logic        rise, fall, hv, ld_high, ld_light, conv_pfm, dual_phase;
   logic [7:0]  vout_code;
   logic [4:0]  oscillator_trim;
   logic        output_good_flag, pg_pin_out, pg_pin_oe_n;
   ctrl_reg_t   ctrl = '0;
   int          miscompares = 0, cmp_count = 0;

   always #4 pclk = ~pclk;

   buck_voltage_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .select_input_pin(sel_pin), .above_good_rising_threshold(rise),
      .below_good_falling_threshold(fall), .above_overvoltage_threshold(hv),
      .load_above_changeover(ld_high), .load_light(ld_light), .vout_code(vout_code),
      .conv_pfm(conv_pfm), .dual_phase(dual_phase), .pulldown_en(pulldown_en),
      .oscillator_trim(oscillator_trim), .output_good_flag(output_good_flag),
      .pg_pin_out(pg_pin_out), .pg_pin_oe_n(pg_pin_oe_n));

   rail_model u_rail (.pclk(pclk), .presetn(presetn), .vout_code(vout_code), .droop(droop),
      .surge(surge), .load_level(load_level), .above_rise(rise), .below_fall(fall),
      .above_hv(hv), .load_high(ld_high), .load_light(ld_light));

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      check("write error", 32'h0, 32'(e));
   endtask : wr

   task automatic set_ctrl();
      wr(`ADDR_CTRL, 32'(ctrl));
   endtask : set_ctrl

   function automatic logic [31:0] bank(input bank_mode_t m, input logic [7:0] c);
      return 32'({m, c});
   endfunction : bank

   task automatic wait_code(input logic [7:0] t);
      logic [7:0] v;
      int         n;
      v = vout_code;
      n = 0;
      while (vout_code !== t && n < 20000) begin
         @(posedge pclk);
         n++;
         if (vout_code !== v) begin
            check("ramp step", 32'((t > v) ? v + 8'h01 : v - 8'h01), 32'(vout_code));
            if (vout_code !== t) check("pwm in ramp", 32'h0, 32'(conv_pfm));
            v = vout_code;
         end
      end
      if (n >= 20000) miscompares++;
   endtask : wait_code

   task automatic t_reset();
      check("pulldown", 32'h3, 32'(pulldown_en));
      check("pin oe_n", 32'h1, 32'(pg_pin_oe_n));
      apb(1'b0, `ADDR_CEILING, 32'h0);
      check("ceiling", 32'h0000_00A0, q);
      apb(1'b0, `ADDR_BANK_B, 32'h0);
      check("bank b", 32'h0, q);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped err", 32'h1, 32'(e));
      repeat (10) @(posedge pclk);
      check("good off", 32'h0, 32'(output_good_flag));
   endtask : t_reset

   task automatic t_ramp();
      ctrl.enable = 1'b1;
      ctrl.rate   = 3'h4;
      set_ctrl();
      wr(`ADDR_BANK_A, bank(MODE_PFM, 8'h03));
      repeat (3) @(posedge pclk);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("ramping", 32'h1, 32'(q[1]));
      wait_code(8'h03);
      repeat (4) @(posedge pclk);
      check("mode resumes", 32'h1, 32'(conv_pfm));
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("status code", 32'h3, 32'(q[15:8]));
   endtask : t_ramp

   task automatic t_rates();
      int         gap_tbl[5] = '{1000, 500, 250, 125, 63};
      int         gap;
      logic [7:0] t;
      for (int r = 0; r < 5; r++) begin
         ctrl.rate = 3'(r);
         set_ctrl();
         t = vout_code + 8'h02;
         wr(`ADDR_BANK_A, bank(MODE_PWM, t));
         while (vout_code !== t - 8'h02 + 8'h01) @(posedge pclk);
         gap = 0;
         while (vout_code !== t && gap < 3000) begin
            @(posedge pclk);
            gap++;
         end
         check("step gap", 32'(gap_tbl[r]), 32'(gap));
      end
      ctrl.rate = 3'h4;
      set_ctrl();
   endtask : t_rates

   task automatic t_banks();
      wr(`ADDR_BANK_B, bank(MODE_PWM, 8'h01));
      repeat (10) @(posedge pclk);
      check("inactive bank", 32'h0D, 32'(vout_code));
      ctrl.bank = 1'b1;
      set_ctrl();
      wait_code(8'h01);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("active bank", 32'h1, 32'(q[2]));
      ctrl.bank = 1'b0;
      set_ctrl();
      wait_code(8'h0D);
      ctrl.pin_sel = 1'b1;
      sel_pin <= 1'b1;
      set_ctrl();
      wait_code(8'h01);
      sel_pin <= 1'b0;
      wait_code(8'h0D);
      ctrl.pin_sel = 1'b0;
      set_ctrl();
   endtask : t_banks

   task automatic t_ceiling();
      wr(`ADDR_CEILING, 32'h2);
      wait_code(8'h02);
      wr(`ADDR_BANK_A, bank(MODE_PWM, 8'h09));
      repeat (200) @(posedge pclk);
      check("ceiling clamp", 32'h2, 32'(vout_code));
      wr(`ADDR_CEILING, 32'hA0);
      wait_code(8'h09);
   endtask : t_ceiling

   task automatic t_modes();
      bank_mode_t m[4] = '{MODE_AUTO, MODE_PFM, MODE_PWM, MODE_AUTO_ALT};
      logic       light_pfm[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_BANK_A, bank(m[i], 8'h09));
         load_level <= 2'h0;
         repeat (8) @(posedge pclk);
         check("light load pfm", 32'(light_pfm[i]), 32'(conv_pfm));
         load_level <= 2'h1;
         repeat (8) @(posedge pclk);
         check("mid load pfm", 32'(m[i] == MODE_PFM), 32'(conv_pfm));
      end
      load_level <= 2'h2;
      repeat (8) @(posedge pclk);
      check("dual phase", 32'h1, 32'(dual_phase));
      load_level <= 2'h1;
      repeat (8) @(posedge pclk);
      check("single phase", 32'h0, 32'(dual_phase));
      wr(`ADDR_BANK_B, bank(MODE_PFM, 8'h09));
      ctrl.bank = 1'b1;
      set_ctrl();
      repeat (8) @(posedge pclk);
      check("bank b mode", 32'h1, 32'(conv_pfm));
      ctrl.bank = 1'b0;
      set_ctrl();
   endtask : t_modes

   task automatic t_good();
      ctrl.pg_pin = 1'b1;
      set_ctrl();
      repeat (10) @(posedge pclk);
      check("good set", 32'h1, 32'(output_good_flag));
      check("good pin", 32'h1, 32'({pg_pin_out, pg_pin_oe_n} == 2'b10));
      apb(1'b0, `ADDR_STATUS, 32'h0);
      check("good status", 32'h1, 32'(q[0]));
      surge <= 1'b1;
      repeat (6) @(posedge pclk);
      check("overvoltage", 32'h0, 32'({output_good_flag, pg_pin_out}));
      surge <= 1'b0;
      repeat (6) @(posedge pclk);
      check("good again", 32'h1, 32'(output_good_flag));
      droop <= 1'b1;
      repeat (6) @(posedge pclk);
      check("droop", 32'h0, 32'(output_good_flag));
      droop <= 1'b0;
      ctrl.pg_pin = 1'b0;
      set_ctrl();
      repeat (3) @(posedge pclk);
      check("pin released", 32'h1, 32'(pg_pin_oe_n));
   endtask : t_good

   task automatic t_misc();
      ctrl.pd_dis = 2'b10;
      set_ctrl();
      repeat (2) @(posedge pclk);
      check("pulldown one", 32'h1, 32'(pulldown_en));
      wr(`ADDR_TRIM, 32'hFFFF_FFF3);
      repeat (2) @(posedge pclk);
      check("trim", 32'h13, 32'(oscillator_trim));
      ctrl.enable = 1'b0;
      set_ctrl();
      repeat (6) @(posedge pclk);
      check("good disabled", 32'h0, 32'(output_good_flag));
   endtask : t_misc

   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ramp();
      t_rates();
      t_banks();
      t_ceiling();
      t_modes();
      t_good();
      t_misc();
      report_and_stop();
   end
endmodule : buck_voltage_control_logic_bench

`default_nettype wire
